// ### design/wakeup_seq_regs.vh
// Timing constants and codes for the low-power wake-up sequencer.
// Assumes a 50 MHz clock; every cycle count is derived from its time in the code.
`ifndef WAKEUP_SEQ_REGS_VH
`define WAKEUP_SEQ_REGS_VH
`define CLK_FREQ_MHZ 50
`define RESET_PERIOD_MS 100
`define RESET_PERIOD_CYC (`RESET_PERIOD_MS * 1000 * `CLK_FREQ_MHZ)
`define RESET_HOLD_MS 4
`define RESET_HOLD_CYC (`RESET_HOLD_MS * 1000 * `CLK_FREQ_MHZ)
`define HV_WAKE_DELAY_US 100
`define HV_WAKE_DELAY_CYC (`HV_WAKE_DELAY_US * `CLK_FREQ_MHZ)
`define CAN_WAKE_DELAY_US 80
`define CAN_WAKE_DELAY_CYC (`CAN_WAKE_DELAY_US * `CLK_FREQ_MHZ)
`define CS_WAKE_DELAY_US 60
`define CS_WAKE_DELAY_CYC (`CS_WAKE_DELAY_US * `CLK_FREQ_MHZ)
`define OC_DEGLITCH_US 55
`define OC_DEGLITCH_CYC (`OC_DEGLITCH_US * `CLK_FREQ_MHZ)
`define OC_WAKE_DELAY_US 60
`define OC_WAKE_DELAY_CYC (`OC_WAKE_DELAY_US * `CLK_FREQ_MHZ)
`define INT_PULSE_US 20
`define INT_PULSE_CYC (`INT_PULSE_US * `CLK_FREQ_MHZ)
`define READY_DELAY_US 13
`define READY_DELAY_CYC (`READY_DELAY_US * `CLK_FREQ_MHZ)
`define SAMPLE_LEAD_US 10
`define SAMPLE_LEAD_CYC (`SAMPLE_LEAD_US * `CLK_FREQ_MHZ)
`define SWITCH_ON_US 200
`define SWITCH_ON_CYC (`SWITCH_ON_US * `CLK_FREQ_MHZ)
`define CAN_WAKE_PULSES 2'h3
`define CAN_MODE_NORMAL 1'b0
`define CAN_MODE_SLEEP 1'b1
`endif

// ### design/sync2.v
// Two-stage synchroniser for a bus of asynchronous level inputs.
// Assumes inputs come from pins outside the clock domain.
`timescale 1ns/1ps
module sync2 #(
  parameter WIDTH = 8
) (
  input wire clock,
  input wire rst_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;
  always @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// ### design/cyclic_sense.v
// Cyclic sense timer: drives the high-side switch and samples the wake inputs.
// Assumes synchronised wake inputs and a period count from the top module.
`timescale 1ns/1ps
`include "wakeup_seq_regs.vh"
module cyclic_sense (
  input wire clock,
  input wire rst_n,
  input wire enable,
  input wire [31:0] period_cyc,
  input wire [3:0] wake_level,
  output reg switch_on,
  output reg [3:0] sampled_level
);
  reg [31:0] count_reg;
  always @(posedge clock) begin
    if (!rst_n || !enable) begin
      count_reg <= 32'h00000000;
      switch_on <= 1'b0;
      sampled_level <= 4'h0;
    end else begin
      if (count_reg + 32'h00000001 >= period_cyc) begin
        count_reg <= 32'h00000000;
      end else begin
        count_reg <= count_reg + 32'h00000001;
      end
      switch_on <= (count_reg < `SWITCH_ON_CYC);
      // Sample point before end of on-time; later levels wait a full cycle
      if (count_reg == `SWITCH_ON_CYC - `SAMPLE_LEAD_CYC) begin
        sampled_level <= wake_level;
      end
    end
  end
endmodule

// ### design/low_power_wakeup_sequencer.v
// Mode and wake-up sequencer for a supervisor chip feeding a host controller.
// Assumes analog comparators deliver level flags; host bits arrive as ports.
`timescale 1ns/1ps
`include "wakeup_seq_regs.vh"
// Summary of operation
// - Undervoltage with sleep selected and battery-fail clear: 100 ms reset, watchdog high.
// - After the reset period, enter sleep with both regulators off.
// - Sleep wake-up turns main regulator on, then releases reset high.
// - Sleep: enabled wake input rising edge turns regulator on after 100 us.
// - After regulator exceeds reset threshold, hold reset at most 4 ms.
// - Sleep: third valid dominant bus pulse turns regulator on after 80 us.
// - Cyclic sense samples wake inputs 10 us before switch on-time ends.
// - Wake level arriving after the sample point waits one full cycle.
// - Stop wake-up: detection, interrupt pulse, ready delay; no reset.
// - Stop: wake input rising edge gives interrupt pulse after 100 us.
// - Stop: third bus pulse gives interrupt pulse after 80 us.
// - Stop: chip select rising edge gives interrupt pulse after 60 us.
// - Stop: overcurrent past 55 us deglitch gives interrupt after 60 us.
// - Host selects transceiver normal or sleep mode; device applies it.
// - Normal transceiver mode offers four slew-rate settings.
// - Transceiver sleep honours host option enabling bus wake-up.
// - Overcurrent stop wake-up pulses interrupt with status left all zero.
module low_power_wakeup_sequencer #(
  parameter RESET_PERIOD_CYC = `RESET_PERIOD_CYC,
  parameter RESET_HOLD_CYC = `RESET_HOLD_CYC,
  parameter HV_WAKE_DELAY_CYC = `HV_WAKE_DELAY_CYC,
  parameter CAN_WAKE_DELAY_CYC = `CAN_WAKE_DELAY_CYC,
  parameter CS_WAKE_DELAY_CYC = `CS_WAKE_DELAY_CYC,
  parameter OC_DEGLITCH_CYC = `OC_DEGLITCH_CYC,
  parameter OC_WAKE_DELAY_CYC = `OC_WAKE_DELAY_CYC,
  parameter INT_PULSE_CYC = `INT_PULSE_CYC,
  parameter READY_DELAY_CYC = `READY_DELAY_CYC
) (
  input wire clock,
  input wire rst_n,
  input wire main_reg_undervoltage,
  input wire main_reg_above_threshold,
  input wire main_reg_overcurrent,
  input wire battery_fail_flag,
  input wire [3:0] hv_wake_input,
  input wire can_dominant_pulse,
  input wire spi_cs_n,
  input wire sleep_request,
  input wire stop_request,
  input wire sleep_is_low_power_mode,
  input wire [3:0] hv_wake_enable,
  input wire can_wake_enable,
  input wire can_mode_cmd,
  input wire [1:0] slew_rate_cmd,
  input wire cyclic_sense_enable,
  input wire [31:0] cyclic_period_cyc,
  output reg reset_out_n,
  output reg int_out_n,
  output reg watchdog_out_n,
  output reg main_regulator_on,
  output reg tracking_regulator_on,
  output reg battery_high_side_switch,
  output reg can_mode,
  output reg [1:0] can_slew_rate,
  output reg can_wake_detect_on,
  output reg [3:0] int_status,
  output reg stop_ready,
  output reg [2:0] mode_state
);
  localparam ST_NORMAL = 3'h0;
  localparam ST_UV_RESET = 3'h1;
  localparam ST_SLEEP = 3'h2;
  localparam ST_WAKE_RAMP = 3'h3;
  localparam ST_WAKE_HOLD = 3'h4;
  localparam ST_STOP = 3'h5;
  localparam ST_STOP_INT = 3'h6;
  localparam ST_STOP_READY = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  wire [7:0] sync_bus;
  sync2 #(.WIDTH(8)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({main_reg_undervoltage, main_reg_above_threshold, main_reg_overcurrent,
               can_dominant_pulse, hv_wake_input}),
    .sync_out(sync_bus)
  );
  wire [3:0] wake_s = sync_bus[3:0];
  wire dom_s = sync_bus[4];
  wire oc_s = sync_bus[5];
  wire above_s = sync_bus[6];
  wire uv_s = sync_bus[7];
  reg cs_meta_reg;
  reg cs_s_reg;
  always @(posedge clock) begin
    if (!rst_n) begin
      cs_meta_reg <= 1'b1;
      cs_s_reg <= 1'b1;
    end else begin
      cs_meta_reg <= spi_cs_n;
      cs_s_reg <= cs_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cyclic sensing of wake inputs
  wire cs_switch;
  wire [3:0] cs_sample;
  cyclic_sense u_cyclic (
    .clock(clock),
    .rst_n(rst_n),
    .enable(cyclic_sense_enable),
    .period_cyc(cyclic_period_cyc),
    .wake_level(wake_s),
    .switch_on(cs_switch),
    .sampled_level(cs_sample)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection
  reg [3:0] wake_prev_reg;
  reg dom_prev_reg;
  reg cs_prev_reg;
  wire [3:0] wake_src = cyclic_sense_enable ? cs_sample : wake_s;
  wire hv_edge = |(wake_src & ~wake_prev_reg & hv_wake_enable);
  wire dom_edge = dom_s & ~dom_prev_reg;
  wire cs_rise = cs_s_reg & ~cs_prev_reg;
  always @(posedge clock) begin
    if (!rst_n) begin
      wake_prev_reg <= 4'h0;
      dom_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      wake_prev_reg <= wake_src;
      dom_prev_reg <= dom_s;
      cs_prev_reg <= cs_s_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [31:0] timer_reg;
  reg [31:0] timer_next;
  reg [31:0] delay_reg;
  reg [31:0] delay_next;
  reg pending_reg;
  reg pending_next;
  reg [1:0] pulse_cnt_reg;
  reg [1:0] pulse_cnt_next;
  reg [31:0] oc_cnt_reg;
  reg oc_wake_reg;
  reg oc_wake_next;
  reg [3:0] int_status_next;
  wire bus_wake_ok = can_wake_enable && (can_mode == `CAN_MODE_SLEEP);
  wire third_pulse = bus_wake_ok && dom_edge && (pulse_cnt_reg == `CAN_WAKE_PULSES - 2'h1);
  wire oc_detect = (oc_cnt_reg == OC_DEGLITCH_CYC - 1) && oc_s;

  // Deglitch counter for overcurrent
  always @(posedge clock) begin
    if (!rst_n || !oc_s) begin
      oc_cnt_reg <= 32'h00000000;
    end else if (oc_cnt_reg < OC_DEGLITCH_CYC) begin
      oc_cnt_reg <= oc_cnt_reg + 32'h00000001;
    end
  end

  always @* begin
    state_next = state_reg;
    timer_next = timer_reg + 32'h00000001;
    delay_next = delay_reg;
    pending_next = pending_reg;
    pulse_cnt_next = pulse_cnt_reg;
    oc_wake_next = oc_wake_reg;
    int_status_next = int_status;
    if (dom_edge && bus_wake_ok) begin
      pulse_cnt_next = third_pulse ? 2'h0 : pulse_cnt_reg + 2'h1;
    end
    case (state_reg)
      ST_NORMAL: begin
        timer_next = 32'h00000000;
        pending_next = 1'b0;
        if (uv_s && sleep_is_low_power_mode && !battery_fail_flag) begin
          state_next = ST_UV_RESET;
        end else if (sleep_request) begin
          state_next = ST_SLEEP;
        end else if (stop_request) begin
          state_next = ST_STOP;
          oc_wake_next = 1'b0;
        end
      end
      ST_UV_RESET: begin
        if (timer_reg >= RESET_PERIOD_CYC - 1) begin
          state_next = ST_SLEEP;
          timer_next = 32'h00000000;
        end
      end
      ST_SLEEP: begin
        if (!pending_reg) begin
          timer_next = 32'h00000000;
          if (hv_edge) begin
            pending_next = 1'b1;
            delay_next = HV_WAKE_DELAY_CYC;
          end else if (third_pulse) begin
            pending_next = 1'b1;
            delay_next = CAN_WAKE_DELAY_CYC;
          end
        end else if (timer_reg >= delay_reg - 1) begin
          state_next = ST_WAKE_RAMP;
          pending_next = 1'b0;
          timer_next = 32'h00000000;
        end
      end
      ST_WAKE_RAMP: begin
        timer_next = 32'h00000000;
        if (above_s) begin
          state_next = ST_WAKE_HOLD;
        end
      end
      ST_WAKE_HOLD: begin
        if (timer_reg >= RESET_HOLD_CYC - 1) begin
          state_next = ST_NORMAL;
        end
      end
      ST_STOP: begin
        if (!pending_reg) begin
          timer_next = 32'h00000000;
          if (hv_edge) begin
            pending_next = 1'b1;
            delay_next = HV_WAKE_DELAY_CYC;
          end else if (third_pulse) begin
            pending_next = 1'b1;
            delay_next = CAN_WAKE_DELAY_CYC;
          end else if (cs_rise) begin
            pending_next = 1'b1;
            delay_next = CS_WAKE_DELAY_CYC;
          end else if (oc_detect) begin
            pending_next = 1'b1;
            oc_wake_next = 1'b1;
            delay_next = OC_WAKE_DELAY_CYC;
          end
        end else if (timer_reg >= delay_reg - 1) begin
          state_next = ST_STOP_INT;
          pending_next = 1'b0;
          timer_next = 32'h00000000;
          // Overcurrent wake leaves status clear; every other source sets the same 4'h1
          int_status_next = oc_wake_reg ? 4'h0 : 4'h1;
        end
      end
      ST_STOP_INT: begin
        if (timer_reg >= INT_PULSE_CYC - 1) begin
          state_next = ST_STOP_READY;
          timer_next = 32'h00000000;
        end
      end
      ST_STOP_READY: begin
        if (timer_reg >= READY_DELAY_CYC - 1) begin
          state_next = ST_NORMAL;
        end
      end
      default: begin
        state_next = ST_NORMAL;
      end
    endcase
    if (state_reg == ST_NORMAL && (sleep_request || stop_request)) begin
      int_status_next = 4'h0;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= ST_NORMAL;
      timer_reg <= 32'h00000000;
      delay_reg <= 32'h00000000;
      pending_reg <= 1'b0;
      pulse_cnt_reg <= 2'h0;
      oc_wake_reg <= 1'b0;
      int_status <= 4'h0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      delay_reg <= delay_next;
      pending_reg <= pending_next;
      pulse_cnt_reg <= pulse_cnt_next;
      oc_wake_reg <= oc_wake_next;
      int_status <= int_status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge clock) begin
    if (!rst_n) begin
      reset_out_n <= 1'b0;
      int_out_n <= 1'b1;
      watchdog_out_n <= 1'b1;
      main_regulator_on <= 1'b1;
      tracking_regulator_on <= 1'b0;
      battery_high_side_switch <= 1'b0;
      can_mode <= `CAN_MODE_NORMAL;
      can_slew_rate <= 2'h0;
      can_wake_detect_on <= 1'b0;
      stop_ready <= 1'b0;
      mode_state <= ST_NORMAL;
    end else begin
      // Reset low in undervoltage, sleep and wake phases, released after hold
      reset_out_n <= !(state_next == ST_UV_RESET || state_next == ST_SLEEP ||
                       state_next == ST_WAKE_RAMP || state_next == ST_WAKE_HOLD);
      int_out_n <= !(state_next == ST_UV_RESET || state_next == ST_STOP_INT);
      watchdog_out_n <= 1'b1;
      main_regulator_on <= !(state_next == ST_SLEEP);
      tracking_regulator_on <= (state_next == ST_NORMAL);
      battery_high_side_switch <= cs_switch;
      can_mode <= can_mode_cmd;
      can_slew_rate <= slew_rate_cmd;
      can_wake_detect_on <= (can_mode_cmd == `CAN_MODE_SLEEP) && can_wake_enable;
      stop_ready <= (state_next == ST_NORMAL) && (state_reg == ST_STOP_READY);
      mode_state <= state_next;
    end
  end
endmodule

// ### tb/wakeup_checker.sv
// Checker: port relations of the wake-up sequencer.
// Assumes binding into the top module with its own count parameters.
`timescale 1ns/1ps
module wakeup_checker #(
  parameter RESET_PERIOD_CYC = 50,
  parameter RESET_HOLD_CYC = 20,
  parameter INT_PULSE_CYC = 4
) (
  input logic clock,
  input logic rst_n,
  input logic battery_fail_flag,
  input logic can_mode_cmd,
  input logic reset_out_n,
  input logic int_out_n,
  input logic watchdog_out_n,
  input logic main_regulator_on,
  input logic tracking_regulator_on,
  input logic can_mode,
  input logic stop_ready,
  input logic [2:0] mode_state
);
  logic [2:0] prev_state;
  logic [31:0] run_cnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // Cycles spent in the current state
  always @(posedge clock) begin
    prev_state <= mode_state;
    if (!rst_n || mode_state != prev_state) run_cnt <= 32'h1;
    else run_cnt <= run_cnt + 32'h1;
  end
  a_watchdog_high: assert property (watchdog_out_n)
    else $error("watchdog low");
  a_uv_pins_low: assert property (mode_state == 3'h1 |-> !reset_out_n && !int_out_n)
    else $error("reset or int high in uv reset");
  a_bf_blocks_uv: assert property
    ((mode_state == 3'h0 && battery_fail_flag)[*4] |=> mode_state != 3'h1)
    else $error("uv reset despite battery fail");
  a_uv_period_end: assert property (prev_state == 3'h1 && mode_state != 3'h1 |->
    mode_state == 3'h2 && run_cnt + 1 >= RESET_PERIOD_CYC && run_cnt <= RESET_PERIOD_CYC + 1)
    else $error("uv reset period wrong");
  a_sleep_regs_off: assert property
    (mode_state == 3'h2 |-> !main_regulator_on && !tracking_regulator_on && !reset_out_n)
    else $error("regulator on in sleep");
  a_hold_bounded: assert property (prev_state == 3'h4 && mode_state != 3'h4 |->
    mode_state == 3'h0 && run_cnt <= RESET_HOLD_CYC + 1)
    else $error("reset hold too long");
  a_stop_keeps_reset: assert property (mode_state >= 3'h5 |-> reset_out_n && !stop_ready)
    else $error("reset low in stop");
  a_ready_pulse: assert property (prev_state == 3'h7 && mode_state == 3'h0 |-> stop_ready)
    else $error("no ready pulse after stop wake");
  a_stop_pulse_width: assert property (prev_state == 3'h6 && mode_state == 3'h7 |->
    int_out_n && run_cnt + 1 >= INT_PULSE_CYC && run_cnt <= INT_PULSE_CYC + 1)
    else $error("int pulse width wrong");
  a_can_mode_copy: assert property ($past(rst_n) |-> can_mode == $past(can_mode_cmd))
    else $error("transceiver mode not applied");
  cover property (mode_state == 3'h6);
  cover property (prev_state == 3'h1 && mode_state == 3'h2);
  cover property (prev_state == 3'h4 && mode_state == 3'h0);
endmodule
bind low_power_wakeup_sequencer wakeup_checker #(.RESET_PERIOD_CYC(RESET_PERIOD_CYC),
  .RESET_HOLD_CYC(RESET_HOLD_CYC), .INT_PULSE_CYC(INT_PULSE_CYC)) u_chk (
  .clock(clock), .rst_n(rst_n), .battery_fail_flag(battery_fail_flag),
  .can_mode_cmd(can_mode_cmd), .reset_out_n(reset_out_n), .int_out_n(int_out_n),
  .watchdog_out_n(watchdog_out_n), .main_regulator_on(main_regulator_on),
  .tracking_regulator_on(tracking_regulator_on), .can_mode(can_mode),
  .stop_ready(stop_ready), .mode_state(mode_state));

// ### tb/host_model.sv
// Host model: pulls chip select low, then releases it to wake the sequencer.
// Assumes a one-cycle request from the bench with a low time in cycles.
`timescale 1ns/1ps
module host_model (
  input logic clock,
  input logic cs_req,
  input logic [2:0] cs_len,
  output logic spi_cs_n
);
  logic [2:0] cnt = 3'h0;
  initial spi_cs_n = 1'b1;
  ////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (cs_req && spi_cs_n) begin
      spi_cs_n <= 1'b0;
      cnt <= cs_len;
    end else if (!spi_cs_n) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h1) spi_cs_n <= 1'b1;
    end
  end
endmodule

// ### tb/low_power_wakeup_sequencer_tb.sv
// Bench: uv reset, sleep and stop wake-ups, transceiver controls.
// Assumes shortened delays and a host model on the chip select.
`timescale 1ns/1ps
`include "wakeup_seq_regs.vh"
module low_power_wakeup_sequencer_tb;
  localparam PER = 50, HOLD = 20, HVD = 10, CAND = 8, CSD = 6, OCG = 5, OCD = 6;
  localparam CYP = 12000;
  typedef struct {int kind; int lo; int hi;} note_t;
  note_t q[$];
  note_t n;
  int fail_count = 0, cmp_count = 0, cyc = 0, t0 = 0, seed = 15, k;
  logic clock, rst_n, uv, above, oc, bf, canp, slp, stp, canwe, cmd, cs_req, spi_cs_n;
  logic rst_o, int_o, main_on, can_md, wake_det, p_int = 1, p_main = 1, p_rst = 1;
  logic slm, cyc_en, hs_sw;
  logic [31:0] cyc_per;
  logic [3:0] hv, stat, hv_en;
  logic [2:0] mode, cs_len;
  logic [1:0] slew, rate;
  low_power_wakeup_sequencer #(.RESET_PERIOD_CYC(PER), .RESET_HOLD_CYC(HOLD),
    .HV_WAKE_DELAY_CYC(HVD), .CAN_WAKE_DELAY_CYC(CAND), .CS_WAKE_DELAY_CYC(CSD),
    .OC_DEGLITCH_CYC(OCG), .OC_WAKE_DELAY_CYC(OCD), .INT_PULSE_CYC(4),
    .READY_DELAY_CYC(3)) u_dut (.clock(clock), .rst_n(rst_n),
    .main_reg_undervoltage(uv), .main_reg_above_threshold(above), .main_reg_overcurrent(oc),
    .battery_fail_flag(bf), .hv_wake_input(hv), .can_dominant_pulse(canp),
    .spi_cs_n(spi_cs_n), .sleep_request(slp), .stop_request(stp),
    .sleep_is_low_power_mode(slm), .hv_wake_enable(hv_en), .can_wake_enable(canwe),
    .can_mode_cmd(cmd), .slew_rate_cmd(slew), .cyclic_sense_enable(cyc_en),
    .cyclic_period_cyc(cyc_per), .reset_out_n(rst_o), .int_out_n(int_o),
    .watchdog_out_n(), .main_regulator_on(main_on), .tracking_regulator_on(),
    .battery_high_side_switch(hs_sw), .can_mode(can_md), .can_slew_rate(rate),
    .can_wake_detect_on(wake_det), .int_status(stat), .stop_ready(), .mode_state(mode));
  host_model u_host (.clock(clock), .cs_req(cs_req), .cs_len(cs_len), .spi_cs_n(spi_cs_n));
  ////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  // Takes the oldest note at each int fall, regulator turn-on or reset release
  always @(negedge clock) begin
    k = (p_int && !int_o) ? 1 : (!p_main && main_on) ? 2 : (!p_rst && rst_o) ? 3 : 0;
    if (rst_n && k != 0 && q.size() > 0) begin
      n = q.pop_front();
      cmp_count++;
      if (k != n.kind || cyc - t0 < n.lo || cyc - t0 > n.hi) begin
        fail_count++;
        $display("MISMATCH event expected %0d in %0d..%0d seen %0d after %0d",
          n.kind, n.lo, n.hi, k, cyc - t0);
      end
    end
    p_int = int_o;
    p_main = main_on;
    p_rst = rst_o;
    if (cyc > 30000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string nm, input logic [3:0] exp, input logic [3:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 400 && mode !== m; i++) @(negedge clock);
    check("mode_state", 4'(m), 4'(mode));
  endtask
  task automatic note(input int kind, input int lo);
    q.push_back('{kind, lo, lo + 10});
    t0 = cyc;
  endtask
  task automatic pulses3(input int kind);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) note(kind, CAND);
      canp = 1'b1;
      repeat (3) @(negedge clock);
      canp = 1'b0;
      repeat (3) @(negedge clock);
    end
  endtask
  task automatic stop_wake(input int src);
    stp = 1'b1;
    @(negedge clock);
    stp = 1'b0;
    wait_mode(3'h5);
    if (src == 0) begin
      hv = 4'h1;
      repeat (20) @(negedge clock);
      note(1, HVD);
      hv = 4'h3;
    end else if (src == 1) pulses3(1);
    else if (src == 2) begin
      cs_len = 3'(2 + ($random(seed) & 3));
      note(1, CSD + cs_len);
      cs_req = 1'b1;
      @(negedge clock);
      cs_req = 1'b0;
    end else begin
      oc = 1'b1;
      repeat (OCG - 3) @(negedge clock);
      oc = 1'b0;
      repeat (5) @(negedge clock);
      note(1, OCG + OCD);
      oc = 1'b1;
    end
    wait_mode(3'h0);
    check("int_status", (src == 3) ? 4'h0 : 4'h1, stat);
    hv = 4'h0;
    oc = 1'b0;
    $display("Test stop wake %0d done", src);
  endtask
  task automatic sleep_wake(input int src);
    if (src == 0) begin
      note(2, HVD);
      hv = 4'h2;
    end else if (src == 1) pulses3(2);
    else begin
      cyc_en = 1'b1;
      repeat (`SWITCH_ON_CYC - `SAMPLE_LEAD_CYC) @(negedge clock);
      check("battery_high_side_switch", 4'h1, 4'(hs_sw));
      note(2, CYP + HVD);
      hv = 4'h2;
      repeat (`SAMPLE_LEAD_CYC + 100) @(negedge clock);
      check("battery_high_side_switch", 4'h0, 4'(hs_sw));
      repeat (CYP - `SAMPLE_LEAD_CYC - 100) @(negedge clock);
    end
    wait_mode(3'h3);
    repeat (2) @(negedge clock);
    q.push_back('{3, 1, HOLD + 8});
    t0 = cyc;
    above = 1'b1;
    wait_mode(3'h0);
    hv = 4'h0;
    cyc_en = 1'b0;
    $display("Test sleep wake %0d done", src);
  endtask
  initial begin
    {rst_n, uv, oc, bf, canp, slp, stp, canwe, cmd, cs_req} = 10'h000;
    {above, cs_len, hv, slew} = {1'b1, 3'h2, 4'h0, 2'h0};
    {slm, hv_en, cyc_en} = {1'b1, 4'h2, 1'b0};
    cyc_per = CYP;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    for (int i = 0; i < 12; i++) begin
      {cmd, canwe} = 2'($random(seed));
      slew = (i < 4) ? 2'(i) : 2'($random(seed));
      repeat (3) @(negedge clock);
      check("can_mode", 4'(cmd), 4'(can_md));
      check("can_slew_rate", 4'(slew), 4'(rate));
      check("can_wake_detect_on", 4'(cmd & canwe), 4'(wake_det));
    end
    $display("Test transceiver controls done");
    {cmd, canwe} = 2'h3;
    for (int s = 0; s < 4; s++) stop_wake(s);
    {bf, uv, above} = 3'h6;
    repeat (20) @(negedge clock);
    check("mode_state", 4'h0, 4'(mode));
    {bf, slm} = 2'h0;
    repeat (20) @(negedge clock);
    check("mode_state", 4'h0, 4'(mode));
    slm = 1'b1;
    wait_mode(3'h1);
    uv = 1'b0;
    wait_mode(3'h2);
    sleep_wake(0);
    for (int s = 1; s < 3; s++) begin
      slp = 1'b1;
      @(negedge clock);
      {slp, above} = 2'h0;
      wait_mode(3'h2);
      sleep_wake(s);
    end
    conclude();
  end
endmodule
